// File: opmode_addr_gen.sv
/*
  Operand address generator and instruction length decoder.
  Assumes the caller presents the opcode class and mode, the operand
  bytes after the opcode, pointer bytes already fetched from memory,
  the two index registers and the next-instruction counter, all
  stable while start is high. Results appear one cycle after start.
*/
`timescale 1ns/1ps
`include "opmode_params.svh"

module opmode_addr_gen (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire opmode_pkg::decode_req_t req,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [7:0] ptr_hi,
  input wire logic [7:0] ptr_lo,
  input wire logic [7:0] index_a,
  input wire logic [7:0] index_b,
  input wire logic [15:0] pc_next,
  output opmode_pkg::addr_result_t result,
  output logic done,
  output logic [15:0] ptr_addr,
  output logic ptr_needed
);

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  wire opmode_pkg::addr_mode_t mode = req.mode;
  wire [7:0] index_val = req.use_second ? index_b : index_a;
  wire [2:0] second_extra = req.use_second ? `SECOND_INDEX_EXTRA : 3'h0;
  wire [15:0] word12 = {byte1, byte2};
  wire [15:0] ptr_word = {ptr_hi, ptr_lo};
  wire [15:0] ptr_byte = {8'h00, ptr_lo};
  wire [15:0] idx16 = {8'h00, index_val};
  wire inherent_op = req.op inside {
    opmode_pkg::op_nop, opmode_pkg::op_trap,
    opmode_pkg::wait_for_interrupt_op, opmode_pkg::op_halt,
    opmode_pkg::op_ret, opmode_pkg::interrupt_return_op,
    opmode_pkg::interrupt_mask_set_op,
    opmode_pkg::interrupt_mask_clear_op,
    opmode_pkg::carry_set_op, opmode_pkg::carry_clear_op,
    opmode_pkg::stack_pointer_reset_op,
    opmode_pkg::byte_multiply_op};
  wire imm_ok = req.op inside {
    opmode_pkg::op_load, opmode_pkg::op_compare,
    opmode_pkg::bit_compare_op, opmode_pkg::op_logic,
    opmode_pkg::op_arith};
  wire long_form = mode inside {
    opmode_pkg::am_long_direct, opmode_pkg::am_idx_long,
    opmode_pkg::am_ind_long, opmode_pkg::am_ind_idx_long};
  wire rmw_op = req.op inside {
    opmode_pkg::op_rmw, opmode_pkg::bit_false_branch_op};
  wire bit_mode = mode inside {
    opmode_pkg::am_bit_direct, opmode_pkg::am_bit_indirect,
    opmode_pkg::am_bit_direct_rel, opmode_pkg::am_bit_indirect_rel};
  wire rel_mode = mode inside {
    opmode_pkg::am_rel_direct, opmode_pkg::am_rel_indirect};
  wire [15:0] rel_off_direct = {{8{byte1[7]}}, byte1};
  wire [15:0] rel_off_ind = {{8{ptr_lo[7]}}, ptr_lo};
  wire [15:0] rel_off_bit = {{8{byte2[7]}}, byte2};
  wire [15:0] rel_off_bit_ind = {{8{byte3[7]}}, byte3};

  // --------------------------------------------------------------
  // effective address, target and length
  // --------------------------------------------------------------
  logic [15:0] ea_d;
  logic [15:0] target_d;
  logic [2:0] len_d;
  logic illegal_d;
  logic ptr_needed_d;

  always_comb begin
    ea_d = 16'h0000;
    target_d = pc_next;
    len_d = `LEN_INHERENT;
    illegal_d = 1'b0;
    ptr_needed_d = 1'b0;
    case (mode)
      opmode_pkg::am_inherent: begin
        len_d = `LEN_INHERENT;
        illegal_d = !(inherent_op || req.op == opmode_pkg::op_rmw
                      || req.op == opmode_pkg::op_load
                      || req.op == opmode_pkg::op_compare);
      end
      opmode_pkg::am_immediate: begin
        len_d = `LEN_BYTE;
        illegal_d = !imm_ok;
      end
      opmode_pkg::am_short_direct: begin
        ea_d = {8'h00, byte1};
        len_d = `LEN_BYTE;
      end
      opmode_pkg::am_long_direct: begin
        ea_d = word12;
        len_d = `LEN_WORD;
      end
      opmode_pkg::am_idx_none: begin
        ea_d = idx16;
        len_d = `LEN_INHERENT;
      end
      opmode_pkg::am_idx_short: begin
        ea_d = idx16 + {8'h00, byte1};
        len_d = `LEN_BYTE;
      end
      opmode_pkg::am_idx_long: begin
        ea_d = word12 + idx16;
        len_d = `LEN_WORD;
      end
      opmode_pkg::am_ind_short: begin
        ea_d = ptr_byte;
        len_d = `LEN_BYTE;
        ptr_needed_d = 1'b1;
      end
      opmode_pkg::am_ind_long: begin
        ea_d = ptr_word;
        len_d = `LEN_BYTE;
        ptr_needed_d = 1'b1;
      end
      opmode_pkg::am_ind_idx_short: begin
        ea_d = ptr_byte + idx16;
        len_d = `LEN_BYTE;
        ptr_needed_d = 1'b1;
      end
      opmode_pkg::am_ind_idx_long: begin
        ea_d = ptr_word + idx16;
        len_d = `LEN_BYTE;
        ptr_needed_d = 1'b1;
      end
      opmode_pkg::am_rel_direct: begin
        target_d = pc_next + rel_off_direct;
        len_d = `LEN_BYTE;
      end
      opmode_pkg::am_rel_indirect: begin
        target_d = pc_next + rel_off_ind;
        len_d = `LEN_BYTE;
        ptr_needed_d = 1'b1;
      end
      opmode_pkg::am_bit_direct: begin
        ea_d = {8'h00, byte1};
        len_d = `LEN_BYTE;
      end
      opmode_pkg::am_bit_indirect: begin
        ea_d = ptr_byte;
        len_d = `LEN_BYTE;
        ptr_needed_d = 1'b1;
      end
      opmode_pkg::am_bit_direct_rel: begin
        ea_d = {8'h00, byte1};
        target_d = pc_next + rel_off_bit;
        len_d = `LEN_WORD;
      end
      opmode_pkg::am_bit_indirect_rel: begin
        ea_d = ptr_byte;
        target_d = pc_next + rel_off_bit_ind;
        len_d = `LEN_WORD;
        ptr_needed_d = 1'b1;
      end
      default: begin
        illegal_d = 1'b1;
      end
    endcase
  end

  // pointer modes carry the pointer address as one extra byte
  wire [2:0] len_ptr = ptr_needed_d ? len_d + `LEN_BYTE : len_d;
  wire idx_mode = mode inside {
    opmode_pkg::am_idx_none, opmode_pkg::am_idx_short,
    opmode_pkg::am_idx_long, opmode_pkg::am_ind_idx_short,
    opmode_pkg::am_ind_idx_long};
  wire [2:0] len_total = idx_mode ? len_ptr + second_extra : len_ptr;
  wire short_violation = rmw_op && long_form;
  wire bitop_mismatch = bit_mode != (req.op == opmode_pkg::bit_false_branch_op
                        || req.op == opmode_pkg::op_rmw) && bit_mode;
  wire rel_mismatch = rel_mode
                      && req.op != opmode_pkg::conditional_relative_jump;
  wire illegal_all = illegal_d || short_violation || bitop_mismatch
                     || rel_mismatch;
  wire [7:0] mask_d = bit_mode ? 8'h01 << req.bit_pos : 8'h00;

  // --------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result <= '0;
      done <= 1'b0;
      ptr_addr <= 16'h0000;
      ptr_needed <= 1'b0;
    end else begin
      done <= start;
      if (start) begin
        result.ea <= ea_d;
        result.target <= target_d;
        result.length <= len_total;
        result.bit_mask <= mask_d;
        result.illegal <= illegal_all;
        result.is_inherent <= mode == opmode_pkg::am_inherent;
        result.mode_idx <= 5'(mode);
        ptr_addr <= {8'h00, byte1};
        ptr_needed <= ptr_needed_d;
      end
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_short_direct_page;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_short_direct
      |=> result.ea <= `PAGE_ZERO_TOP && result.length == `LEN_BYTE;
  endproperty
  a_short_direct_page: assert property (p_short_direct_page)
    else $error("short direct outside page zero");

  property p_long_direct;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_long_direct
      |=> result.ea == $past(word12) && result.length == `LEN_WORD;
  endproperty
  a_long_direct: assert property (p_long_direct)
    else $error("long direct address wrong");

  property p_short_idx_reach;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_idx_short
      |=> result.ea <= `SHORT_IDX_TOP;
  endproperty
  a_short_idx_reach: assert property (p_short_idx_reach)
    else $error("short indexed beyond reach");

  property p_idx_none;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_idx_none
      |=> result.ea == {8'h00, $past(index_val)}
          && result.length == 3'($past(second_extra));
  endproperty
  a_idx_none: assert property (p_idx_none)
    else $error("no-offset indexed wrong");

  property p_second_index;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_idx_short && req.use_second
      |=> result.length == `LEN_WORD;
  endproperty
  a_second_index: assert property (p_second_index)
    else $error("second index length wrong");

  property p_inherent_len;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_inherent
      |=> result.length == `LEN_INHERENT && result.is_inherent;
  endproperty
  a_inherent_len: assert property (p_inherent_len)
    else $error("inherent length not zero");

  property p_rmw_short;
    @(posedge clk_sys) disable iff (rst)
      start && req.op == opmode_pkg::op_rmw && long_form
      |=> result.illegal;
  endproperty
  a_rmw_short: assert property (p_rmw_short)
    else $error("long form accepted for memory operation");

  property p_rel_reach;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_rel_direct
      |=> result.target - $past(pc_next) + 16'h0080 <= 16'h00ff;
  endproperty
  a_rel_reach: assert property (p_rel_reach)
    else $error("relative target out of reach");

  property p_immediate;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_immediate
      |=> result.length == `LEN_BYTE && result.illegal != $past(imm_ok);
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate length or legality wrong");

  property p_inherent_ops;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_inherent && inherent_op
      |=> !result.illegal && result.length == `LEN_INHERENT;
  endproperty
  a_inherent_ops: assert property (p_inherent_ops)
    else $error("inherent operation refused");

  property p_idx_long;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_idx_long
      |=> result.ea == $past(word12) + $past(idx16)
          && result.length == `LEN_WORD + $past(second_extra);
  endproperty
  a_idx_long: assert property (p_idx_long)
    else $error("long indexed address wrong");

  property p_ind_short;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_ind_short
      |=> result.ea == {8'h00, $past(ptr_lo)} && ptr_needed
          && result.length == `LEN_WORD;
  endproperty
  a_ind_short: assert property (p_ind_short)
    else $error("short indirect address wrong");

  property p_ind_long;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_ind_long
      |=> result.ea == {$past(ptr_hi), $past(ptr_lo)} && ptr_needed;
  endproperty
  a_ind_long: assert property (p_ind_long)
    else $error("long indirect address wrong");

  property p_ind_idx;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_ind_idx_short
      |=> result.ea == $past(ptr_byte) + $past(idx16)
          && result.ea <= `SHORT_IDX_TOP;
  endproperty
  a_ind_idx: assert property (p_ind_idx)
    else $error("indirect indexed address wrong");

  property p_rel_offset;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_rel_direct
      |=> result.target == $past(pc_next) + $past(rel_off_direct);
  endproperty
  a_rel_offset: assert property (p_rel_offset)
    else $error("relative offset not signed");

  property p_rel_indirect;
    @(posedge clk_sys) disable iff (rst)
      start && mode == opmode_pkg::am_rel_indirect
      |=> result.target == $past(pc_next) + $past(rel_off_ind)
          && ptr_needed && ptr_addr == {8'h00, $past(byte1)};
  endproperty
  a_rel_indirect: assert property (p_rel_indirect)
    else $error("relative indirect target wrong");

  property p_bit_select;
    @(posedge clk_sys) disable iff (rst)
      start && bit_mode
      |=> $onehot(result.bit_mask) && result.bit_mask[$past(req.bit_pos)]
          && result.ea <= `PAGE_ZERO_TOP;
  endproperty
  a_bit_select: assert property (p_bit_select)
    else $error("bit selection wrong");

  property p_done_pulse;
    @(posedge clk_sys) disable iff (rst)
      start |=> done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done missing after start");

endmodule : opmode_addr_gen

// File: opmode_params.svh
/*
  Constants for the operand address generator: field positions,
  lengths, page limits and the mode count.
  Assumes inclusion by the address generator only.
*/
`ifndef OPMODE_PARAMS_SVH
`define OPMODE_PARAMS_SVH

`define MODE_COUNT 17
`define PAGE_ZERO_TOP 16'h00ff
`define SHORT_IDX_TOP 16'h01fe
`define SECOND_INDEX_EXTRA 3'h1
`define LEN_INHERENT 3'h0
`define LEN_BYTE 3'h1
`define LEN_WORD 3'h2
`define LEN_BIT_IND_REL 3'h3
`define BITPOS_LSB 0
`define BITPOS_MSB 2

`endif

// File: opmode_pkg.sv
/*
  Types for the operand address generator: mode and operation
  enumerations, the decode request and the address result.
  Assumes the opcode decoder upstream supplies mode and class.
*/
package opmode_pkg;

  typedef enum logic [4:0] {
    am_inherent,
    am_immediate,
    am_short_direct,
    am_long_direct,
    am_idx_none,
    am_idx_short,
    am_idx_long,
    am_ind_short,
    am_ind_long,
    am_ind_idx_short,
    am_ind_idx_long,
    am_rel_direct,
    am_rel_indirect,
    am_bit_direct,
    am_bit_indirect,
    am_bit_direct_rel,
    am_bit_indirect_rel
  } addr_mode_t;

  typedef enum logic [4:0] {
    op_none,
    op_nop,
    op_trap,
    wait_for_interrupt_op,
    op_halt,
    op_ret,
    interrupt_return_op,
    interrupt_mask_set_op,
    interrupt_mask_clear_op,
    carry_set_op,
    carry_clear_op,
    stack_pointer_reset_op,
    byte_multiply_op,
    op_load,
    op_compare,
    bit_compare_op,
    op_logic,
    op_arith,
    op_rmw,
    bit_false_branch_op,
    conditional_relative_jump
  } op_class_t;

  typedef struct packed {
    addr_mode_t mode;
    op_class_t op;
    logic use_second;
    logic [2:0] bit_pos;
  } decode_req_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] target;
    logic [2:0] length;
    logic [7:0] bit_mask;
    logic illegal;
    logic is_inherent;
    logic [4:0] mode_idx;
  } addr_result_t;

endpackage : opmode_pkg

// File: page_memory.sv
/*
  Page-zero memory model that hands pointer bytes to the generator.
  Assumes the bench drives the pointer address and the pointer width.
*/
`timescale 1ns/1ps

module page_memory (
  input wire logic [15:0] addr,
  input wire logic word,
  output logic [7:0] ptr_hi,
  output logic [7:0] ptr_lo
);
  // ----------------------------------------
  // storage and read lanes
  // ----------------------------------------
  logic [7:0] mem [256];
  logic [7:0] a_lo;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 37 + 11);
    end
  end

  assign a_lo = addr[7:0];
  // word pointer high byte first; byte pointer on low lane, its complement on high lane
  assign ptr_hi = word ? mem[a_lo] : ~mem[a_lo];
  assign ptr_lo = word ? mem[8'(a_lo + 8'h01)] : mem[a_lo];
endmodule : page_memory

// File: operand_addressing_modes_test.sv
/*
  Self-checking bench for the operand address generator.
  Assumes page_memory serves pointer bytes at {00,byte1}.
*/
`timescale 1ns/1ps

module operand_addressing_modes_test;
  typedef struct packed {
    opmode_pkg::addr_result_t r;
    logic ev;
    logic pn;
    logic [7:0] pa;
  } exp_t;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  opmode_pkg::decode_req_t req = '0;
  logic [7:0] byte1 = 8'h00;
  logic [7:0] byte2 = 8'h00;
  logic [7:0] byte3 = 8'h00;
  logic [7:0] index_a = 8'h00;
  logic [7:0] index_b = 8'h00;
  logic [15:0] pc_next = 16'h0000;
  logic [7:0] ptr_hi;
  logic [7:0] ptr_lo;
  logic ptr_word;
  opmode_pkg::addr_result_t result;
  logic done;
  logic [15:0] ptr_addr;
  logic ptr_needed;
  exp_t exp_q[$];
  exp_t e;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int m;
  int o;
  int k;
  int pool[6] = '{13, 14, 15, 16, 17, 18};
  int len_tab[17] = '{0, 1, 1, 2, 0, 1, 2, 2, 2, 2, 2, 1, 2, 1, 2, 2, 3};

  always #2 clk_sys = ~clk_sys;

  assign ptr_word = req.mode inside {opmode_pkg::am_ind_long,
                                     opmode_pkg::am_ind_idx_long};

  opmode_addr_gen opmode_addr_gen_inst (
    .clk_sys(clk_sys), .rst(rst), .start(start), .req(req),
    .byte1(byte1), .byte2(byte2), .byte3(byte3),
    .ptr_hi(ptr_hi), .ptr_lo(ptr_lo),
    .index_a(index_a), .index_b(index_b), .pc_next(pc_next),
    .result(result), .done(done), .ptr_addr(ptr_addr),
    .ptr_needed(ptr_needed)
  );

  page_memory page_memory_inst (
    .addr({8'h00, byte1}), .word(ptr_word),
    .ptr_hi(ptr_hi), .ptr_lo(ptr_lo)
  );

  // ----------------------------------------
  // reference model and comparison
  // ----------------------------------------
  function automatic exp_t model();
    exp_t x;
    int mm;
    int oo;
    logic s;
    logic [15:0] ix;
    logic [15:0] pw;
    logic [7:0] ofs;
    x = '0;
    mm = int'(req.mode);
    oo = int'(req.op);
    s = req.use_second;
    ix = 16'(s ? index_b : index_a);
    pw = {ptr_hi, ptr_lo};
    x.ev = 1'b1;
    x.pa = byte1;
    x.r.mode_idx = req.mode;
    x.r.is_inherent = (mm == 0);
    x.r.length = 3'(len_tab[mm] + ((mm inside {4, 5, 6, 9, 10}) ? s : 0));
    x.r.bit_mask = (mm >= 13) ? (8'h01 << req.bit_pos) : 8'h00;
    x.pn = mm inside {[7:10], 12, 14, 16};
    case (mm)
      2, 13, 15: x.r.ea = {8'h00, byte1};
      3: x.r.ea = {byte1, byte2};
      4: x.r.ea = ix;
      5: x.r.ea = ix + 16'(byte1);
      6: x.r.ea = {byte1, byte2} + ix;
      7, 14, 16: x.r.ea = {8'h00, ptr_lo};
      8: x.r.ea = pw;
      9: x.r.ea = ix + 16'(ptr_lo);
      10: x.r.ea = pw + ix;
      default: x.ev = 1'b0;
    endcase
    case (mm)
      0: x.r.illegal = !(oo inside {[1:14], 18});
      1: x.r.illegal = !(oo inside {[13:17]});
      3, 6, 8, 10: x.r.illegal = oo inside {18, 19};
      11, 12: x.r.illegal = (oo != 20);
      13, 14, 15, 16: x.r.illegal = !(oo inside {18, 19});
      default: x.r.illegal = 1'b0;
    endcase
    case (mm)
      11: ofs = byte1;
      12: ofs = ptr_lo;
      15: ofs = byte2;
      default: ofs = byte3;
    endcase
    x.r.target = pc_next;
    if (mm inside {11, 12, 15, 16}) begin
      x.r.target = pc_next + {{8{ofs[7]}}, ofs};
    end
    x.ev = x.ev && !x.r.illegal;
    return x;
  endfunction : model

  task automatic chk(input logic [15:0] g, input logic [15:0] ex);
    compares++;
    if (g !== ex) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, ex);
    end
  endtask : chk

  always @(posedge clk_sys) begin
    #1;
    if (!rst && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk(16'(done), 16'h0001);
      chk(16'(result.length), 16'(e.r.length));
      chk(16'(result.illegal), 16'(e.r.illegal));
      if (e.ev) chk(result.ea, e.r.ea);
      if (!e.r.illegal) chk(result.target, e.r.target);
      if (!e.r.illegal) chk(16'(result.bit_mask), 16'(e.r.bit_mask));
      chk(16'(result.is_inherent), 16'(e.r.is_inherent));
      chk(16'(result.mode_idx), 16'(e.r.mode_idx));
      chk(ptr_addr, {8'h00, e.pa});
      chk(16'(ptr_needed), 16'(e.pn));
    end else if (!rst) begin
      chk(16'(done), 16'h0000);
    end
  end

  task automatic issue(input int mi, input int oi, input logic s,
                       input logic [7:0] b1, input logic [7:0] b2,
                       input logic [7:0] ia);
    @(posedge clk_sys);
    start <= 1'b1;
    req <= '{opmode_pkg::addr_mode_t'(mi), opmode_pkg::op_class_t'(oi),
             s, 3'($urandom)};
    byte1 <= b1;
    byte2 <= b2;
    byte3 <= 8'($urandom);
    index_a <= ia;
    index_b <= 8'($urandom);
    pc_next <= 16'($urandom);
    #3;
    exp_q.push_back(model());
  endtask : issue

  task automatic end_sim();
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(53784));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #2;
    chk(16'(result === '0), 16'h0001);
    for (int i = 0; i < 17; i++) begin
      o = (i inside {11, 12}) ? 20 : (i >= 13) ? 19 : (i == 0) ? 1 : 13;
      issue(i, o, 1'b0, 8'($urandom), 8'($urandom), 8'($urandom));
    end
    for (int i = 1; i < 21; i++) begin
      issue(0, i, 1'b0, 8'h00, 8'h00, 8'h00);
    end
    issue(5, 13, 1'b0, 8'hff, 8'h00, 8'hff);
    issue(4, 13, 1'b1, 8'h00, 8'h00, 8'h00);
    issue(3, 13, 1'b0, 8'hff, 8'hff, 8'h00);
    issue(2, 18, 1'b0, 8'hff, 8'h00, 8'h00);
    issue(3, 18, 1'b0, 8'h12, 8'h34, 8'h00);
    issue(6, 19, 1'b0, 8'h12, 8'h34, 8'h00);
    issue(10, 18, 1'b1, 8'h40, 8'h00, 8'h10);
    issue(11, 20, 1'b0, 8'h80, 8'h00, 8'h00);
    issue(11, 20, 1'b0, 8'h7f, 8'h00, 8'h00);
    issue(8, 13, 1'b0, 8'hff, 8'h00, 8'h00);
    for (int i = 0; i < 400; i++) begin
      m = $urandom_range(16);
      k = (m inside {3, 6, 8, 10}) ? 4 : 5;
      o = (m inside {[2:10]}) ? pool[$urandom_range(k)] : $urandom_range(20, 1);
      issue(m, o, 1'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    end
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (3) @(posedge clk_sys);
    end_sim();
  end
endmodule : operand_addressing_modes_test
